//--- design/sdf_map.svh
// offsets, field positions, reset values and timing counts of the soft flag bank
`ifndef SDF_MAP_SVH
`define SDF_MAP_SVH
`define SDF_OFS_CMD      8'h6e
`define SDF_OFS_ALM_MAIN 8'h70
`define SDF_OFS_ALM_RX   8'h71
`define SDF_OFS_EQ       8'h72
`define SDF_OFS_EMPH     8'h73
`define SDF_OFS_WRN_MAIN 8'h74
`define SDF_OFS_WRN_RX   8'h75
`define SDF_OFS_EXTRA    8'h76
`define SDF_BIT_SOFT_OFF 6
`define SDF_BIT_SW_RX    3
`define SDF_BIT_SW_TX    3
`define SDF_RST_BYTE     8'h00
`define SDF_RESP_TIME_MS 100
`define SDF_CLK_MHZ      250
`define SDF_RESP_CYCLES  (`SDF_RESP_TIME_MS * 1000 * `SDF_CLK_MHZ)
`endif

//--- design/sdf_pkg.sv
// types of the soft flag bank
package sdf_pkg;
    typedef enum logic {
        SDF_LK_IDLE,
        SDF_LK_WAIT
    } sdf_lk_state_t;

    typedef struct packed {
        logic [4:0] pin1;
        logic [4:0] pin2;
        logic       req1;
        logic       req2;
        logic       req3;
        logic       ack_t;
        logic       soft_tx_off;
        logic       sw_rx_rate_high;
        logic       sw_tx_rate_high;
        logic [7:0] tx_input_equalizer;
        logic [7:0] rx_output_preemphasis;
        logic [7:0] alm_main;
        logic [1:0] alm_rx;
        logic [7:0] wrn_main;
        logic [1:0] wrn_rx;
        logic [7:0] rdata;
        logic       tx_off;
        logic       tx_rate_high;
        logic       rx_rate_high;
        logic [2:0] emph_db;
        logic       emph_vendor;
    } sdf_core_t;

    typedef struct packed {
        sdf_lk_state_t st;
        logic          req_t;
        logic [7:0]    addr;
        logic          wr;
        logic [7:0]    wdata;
        logic          ack1;
        logic          ack2;
        logic          ack3;
        logic [7:0]    rdata;
        logic          done;
    } sdf_link_t;
endpackage

//--- design/sdf_flags.sv
// soft command, status and latched flag bytes of the diagnostic page
`timescale 1ns/100ps
`default_nettype none
`include "sdf_map.svh"
module sdf_flags
    import sdf_pkg::*;
#(
    parameter int RESP_CYCLES = `SDF_RESP_CYCLES
) (
    // core clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // link side byte access port
    input  wire logic             lk_clk,
    input  wire logic             lk_rst_b,
    input  wire logic             lk_req,
    input  wire logic             lk_wr,
    input  wire logic [7:0]       lk_addr,
    input  wire logic [7:0]       lk_wdata,
    output logic                  lk_ready,
    output logic                  lk_done,
    output logic [7:0]            lk_rdata,
    // module pins, asynchronous
    input  wire logic             tx_disable_pin,
    input  wire logic             tx_rate_pin_level,
    input  wire logic             rx_rate_pin_level,
    input  wire logic             tx_fault_pin,
    input  wire logic             signal_loss_pin_level,
    // monitor, same clock
    input  wire logic             sense_valid,
    input  wire logic             mon_update,
    input  wire logic [4:0][15:0] mon_value,
    input  wire logic [4:0][15:0] alarm_hi_lim,
    input  wire logic [4:0][15:0] alarm_lo_lim,
    input  wire logic [4:0][15:0] warn_hi_lim,
    input  wire logic [4:0][15:0] warn_lo_lim,
    // effective controls
    output logic                  tx_off,
    output logic                  tx_rate_high,
    output logic                  rx_rate_high,
    output logic [2:0]            emph_db,
    output logic                  emph_vendor
);
    ////////////////////////////////////////////////////////////////////////
    // limit compares, channel 0 temperature signed, others unsigned
    logic [4:0] a_hi;
    logic [4:0] a_lo;
    logic [4:0] w_hi;
    logic [4:0] w_lo;

    for (genvar c = 0; c < 5; c++) begin : g_cmp
        if (c == 0) begin : g_signed
            assign a_hi[c] = $signed(mon_value[c]) > $signed(alarm_hi_lim[c]);
            assign a_lo[c] = $signed(mon_value[c]) < $signed(alarm_lo_lim[c]);
            assign w_hi[c] = $signed(mon_value[c]) > $signed(warn_hi_lim[c]);
            assign w_lo[c] = $signed(mon_value[c]) < $signed(warn_lo_lim[c]);
        end else begin : g_unsigned
            assign a_hi[c] = mon_value[c] > alarm_hi_lim[c];
            assign a_lo[c] = mon_value[c] < alarm_lo_lim[c];
            assign w_hi[c] = mon_value[c] > warn_hi_lim[c];
            assign w_lo[c] = mon_value[c] < warn_lo_lim[c];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core domain
    sdf_core_t  s_q;
    sdf_core_t  s_d;
    sdf_link_t  l_q;
    sdf_link_t  l_d;
    logic       acc;
    logic       acc_wr;
    logic [7:0] acc_addr;
    logic [7:0] cmd_byte;
    logic [7:0] alm_set;
    logic [7:0] wrn_set;
    logic [3:0] nib;

    assign acc      = s_q.req2 ^ s_q.req3;
    assign acc_wr   = l_q.wr;
    assign acc_addr = l_q.addr;
    assign cmd_byte = {s_q.pin2[0], s_q.soft_tx_off, s_q.pin2[1], s_q.pin2[2],
                       s_q.sw_rx_rate_high, s_q.pin2[3], s_q.pin2[4],
                       ~sense_valid};

    always_comb begin
        s_d      = s_q;
        alm_set  = 8'h00;
        wrn_set  = 8'h00;
        s_d.pin1 = {signal_loss_pin_level, tx_fault_pin, rx_rate_pin_level,
                    tx_rate_pin_level, tx_disable_pin};
        s_d.pin2 = s_q.pin1;
        s_d.req1 = l_q.req_t;
        s_d.req2 = s_q.req1;
        s_d.req3 = s_q.req2;
        for (int c = 0; c < 4; c++) begin
            alm_set[7-2*c] = a_hi[c];
            alm_set[6-2*c] = a_lo[c];
            wrn_set[7-2*c] = w_hi[c];
            wrn_set[6-2*c] = w_lo[c];
        end
        if (acc) begin
            s_d.ack_t = ~s_q.ack_t;
            unique case (acc_addr)
                `SDF_OFS_CMD:      s_d.rdata = cmd_byte;
                `SDF_OFS_ALM_MAIN: s_d.rdata = s_q.alm_main;
                `SDF_OFS_ALM_RX:   s_d.rdata = {s_q.alm_rx, 6'h00};
                `SDF_OFS_EQ:       s_d.rdata = s_q.tx_input_equalizer;
                `SDF_OFS_EMPH:     s_d.rdata = s_q.rx_output_preemphasis;
                `SDF_OFS_WRN_MAIN: s_d.rdata = s_q.wrn_main;
                `SDF_OFS_WRN_RX:   s_d.rdata = {s_q.wrn_rx, 6'h00};
                `SDF_OFS_EXTRA:    s_d.rdata = {4'h0, s_q.sw_tx_rate_high, 3'h0};
                default:           s_d.rdata = 8'h00;
            endcase
            if (acc_wr) begin
                unique case (acc_addr)
                    `SDF_OFS_CMD: begin
                        s_d.soft_tx_off     = l_q.wdata[`SDF_BIT_SOFT_OFF];
                        s_d.sw_rx_rate_high = l_q.wdata[`SDF_BIT_SW_RX];
                    end
                    `SDF_OFS_EQ:    s_d.tx_input_equalizer    = l_q.wdata;
                    `SDF_OFS_EMPH:  s_d.rx_output_preemphasis = l_q.wdata;
                    `SDF_OFS_EXTRA: s_d.sw_tx_rate_high = l_q.wdata[`SDF_BIT_SW_TX];
                    default: ;
                endcase
            end else begin
                unique case (acc_addr)
                    `SDF_OFS_ALM_MAIN: s_d.alm_main = 8'h00;
                    `SDF_OFS_ALM_RX:   s_d.alm_rx   = 2'b00;
                    `SDF_OFS_WRN_MAIN: s_d.wrn_main = 8'h00;
                    `SDF_OFS_WRN_RX:   s_d.wrn_rx   = 2'b00;
                    default: ;
                endcase
            end
        end
        // a new event wins over a read clear in the same cycle
        if (mon_update) begin
            s_d.alm_main = s_d.alm_main | alm_set;
            s_d.alm_rx   = s_d.alm_rx | {a_hi[4], a_lo[4]};
            s_d.wrn_main = s_d.wrn_main | wrn_set;
            s_d.wrn_rx   = s_d.wrn_rx | {w_hi[4], w_lo[4]};
        end
        s_d.tx_off       = s_q.pin2[0] | s_q.soft_tx_off;
        s_d.tx_rate_high = s_q.pin2[1] | s_q.sw_tx_rate_high;
        s_d.rx_rate_high = s_q.pin2[2] | s_q.sw_rx_rate_high;
        nib = s_q.rx_rate_high ? s_q.rx_output_preemphasis[7:4]
                               : s_q.rx_output_preemphasis[3:0];
        s_d.emph_vendor = nib[3];
        s_d.emph_db     = nib[3] ? 3'h0 : nib[2:0];
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tx_off       = s_q.tx_off;
    assign tx_rate_high = s_q.tx_rate_high;
    assign rx_rate_high = s_q.rx_rate_high;
    assign emph_db      = s_q.emph_db;
    assign emph_vendor  = s_q.emph_vendor;

    ////////////////////////////////////////////////////////////////////////
    // link domain: capture request, toggle across, wait for ack toggle
    always_comb begin
        l_d      = l_q;
        l_d.done = 1'b0;
        l_d.ack1 = s_q.ack_t;
        l_d.ack2 = l_q.ack1;
        l_d.ack3 = l_q.ack2;
        unique case (l_q.st)
            SDF_LK_IDLE: begin
                if (lk_req) begin
                    l_d.addr  = lk_addr;
                    l_d.wr    = lk_wr;
                    l_d.wdata = lk_wdata;
                    l_d.req_t = ~l_q.req_t;
                    l_d.st    = SDF_LK_WAIT;
                end
            end
            SDF_LK_WAIT: begin
                if (l_q.ack2 ^ l_q.ack3) begin
                    l_d.rdata = s_q.rdata;
                    l_d.done  = 1'b1;
                    l_d.st    = SDF_LK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge lk_clk) begin
        if (!lk_rst_b) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    assign lk_ready = (l_q.st == SDF_LK_IDLE);
    assign lk_done  = l_q.done;
    assign lk_rdata = l_q.rdata;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_read_of(logic [7:0] a);
        acc && !acc_wr && acc_addr == a;
    endsequence

    sequence s_write_of(logic [7:0] a);
        acc && acc_wr && acc_addr == a;
    endsequence

    chk_txoff_follows: assert property ($rose(tx_disable_pin) |-> ##[3:4] tx_off)
        else $error("tx_off did not follow the disable pin");
    chk_pin_response: assert property ($rose(tx_fault_pin) |-> ##[2:3] s_q.pin2[3])
        else $error("fault pin not seen in time");
    chk_cmd_bit7: assert property (s_read_of(`SDF_OFS_CMD) |=> s_q.rdata[7] == $past(s_q.pin2[0]))
        else $error("command bit 7 does not show the disable pin");
    chk_cmd_ready: assert property (s_read_of(`SDF_OFS_CMD) |=> s_q.rdata[0] == !$past(sense_valid))
        else $error("ready bit wrong");
    chk_alarm_hold: assert property (
            s_q.alm_main[7] && !(acc && !acc_wr && acc_addr == `SDF_OFS_ALM_MAIN)
            |=> s_q.alm_main[7])
        else $error("alarm flag lost without a read");
    chk_read_clear: assert property (s_read_of(`SDF_OFS_ALM_MAIN) ##0 !mon_update
            |=> s_q.alm_main == 8'h00 ##0 s_q.rdata == $past(s_q.alm_main))
        else $error("alarm read did not clear or return the flags");
    chk_set_wins: assert property (mon_update && a_hi[0] |=> s_q.alm_main[7])
        else $error("temperature alarm not latched");
    chk_rx_rsvd: assert property (s_read_of(`SDF_OFS_WRN_RX) |=> s_q.rdata[5:0] == 6'h00)
        else $error("reserved warning bits not zero");
    chk_extra_rsvd: assert property (s_read_of(`SDF_OFS_EXTRA) |=> (s_q.rdata & 8'hf7) == 8'h00)
        else $error("reserved bits of byte 118 not zero");
    chk_tx_rate: assert property (s_write_of(`SDF_OFS_EXTRA) ##0 l_q.wdata[3] |-> ##2 tx_rate_high)
        else $error("soft tx rate did not select high rate");
    chk_rx_rate: assert property (s_write_of(`SDF_OFS_CMD) ##0 l_q.wdata[3] |-> ##2 rx_rate_high)
        else $error("soft rx rate did not select high rate");
    chk_emph_vendor: assert property (s_q.rx_output_preemphasis[3] && !s_q.rx_rate_high
            |=> emph_vendor && emph_db == 3'h0)
        else $error("vendor emphasis code not flagged");
    chk_link_done: assert property (@(posedge lk_clk) disable iff (!lk_rst_b)
            lk_req && lk_ready |-> ##[4:9] lk_done)
        else $error("link access not answered in time");

    sequence s_clean_read_of(logic [7:0] a);
        s_read_of(a) ##0 !mon_update;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // command byte layout
    chk_cmd_bit6: assert property (
            s_read_of(`SDF_OFS_CMD) |=> s_q.rdata[6] == $past(s_q.soft_tx_off))
        else $error("command bit 6 does not show the soft off bit");
    chk_cmd_bit5: assert property (
            s_read_of(`SDF_OFS_CMD) |=> s_q.rdata[5] == $past(s_q.pin2[1]))
        else $error("command bit 5 does not show the tx rate pin");
    chk_cmd_bit4: assert property (
            s_read_of(`SDF_OFS_CMD) |=> s_q.rdata[4] == $past(s_q.pin2[2]))
        else $error("command bit 4 does not show the rx rate pin");
    chk_cmd_bit3: assert property (
            s_read_of(`SDF_OFS_CMD) |=> s_q.rdata[3] == $past(s_q.sw_rx_rate_high))
        else $error("command bit 3 does not show the soft rx rate");
    chk_cmd_bit2: assert property (
            s_read_of(`SDF_OFS_CMD) |=> s_q.rdata[2] == $past(s_q.pin2[3]))
        else $error("command bit 2 does not show the fault pin");
    chk_cmd_bit1: assert property (
            s_read_of(`SDF_OFS_CMD) |=> s_q.rdata[1] == $past(s_q.pin2[4]))
        else $error("command bit 1 does not show the loss pin");

    ////////////////////////////////////////////////////////////////////////
    // flag latching
    chk_alm_rx_rsvd: assert property (
            s_read_of(`SDF_OFS_ALM_RX) |=> s_q.rdata[5:0] == 6'h00)
        else $error("reserved alarm bits not zero");
    chk_rx_alarm_hi: assert property (
            mon_update && a_hi[4] |=> s_q.alm_rx[1])
        else $error("rx power high alarm not latched");
    chk_rx_alarm_lo: assert property (
            mon_update && a_lo[4] |=> s_q.alm_rx[0])
        else $error("rx power low alarm not latched");
    chk_rx_warn_hi: assert property (
            mon_update && w_hi[4] |=> s_q.wrn_rx[1])
        else $error("rx power high warning not latched");
    chk_rx_warn_lo: assert property (
            mon_update && w_lo[4] |=> s_q.wrn_rx[0])
        else $error("rx power low warning not latched");
    chk_warn_supply: assert property (
            mon_update && w_hi[1] |=> s_q.wrn_main[5])
        else $error("supply high warning not latched");
    chk_warn_temp: assert property (
            mon_update && w_lo[0] |=> s_q.wrn_main[6])
        else $error("temperature low warning not latched");
    chk_alarm_supply: assert property (
            mon_update && a_hi[1] |=> s_q.alm_main[5])
        else $error("supply high alarm not latched");
    chk_alarm_bias: assert property (
            mon_update && a_lo[2] |=> s_q.alm_main[2])
        else $error("bias low alarm not latched");
    chk_alarm_txp: assert property (
            mon_update && a_lo[3] |=> s_q.alm_main[0])
        else $error("tx power low alarm not latched");
    chk_warn_clear: assert property (
            s_clean_read_of(`SDF_OFS_WRN_MAIN) |=> s_q.wrn_main == 8'h00)
        else $error("warning read did not clear the flags");
    chk_rx_clear: assert property (
            s_clean_read_of(`SDF_OFS_ALM_RX) |=> s_q.alm_rx == 2'b00)
        else $error("rx alarm read did not clear the flags");
    chk_flag_no_set: assert property (
            !mon_update |=> (s_q.alm_main & ~$past(s_q.alm_main)) == 8'h00)
        else $error("alarm flag set without an update");
    chk_flag_wr_ign: assert property (
            s_write_of(`SDF_OFS_ALM_MAIN) |=> $stable(s_q.alm_main) || $past(mon_update))
        else $error("write changed the alarm flags");
    chk_unmapped_rd: assert property (
            acc && !acc_wr && acc_addr > `SDF_OFS_EXTRA |=> s_q.rdata == 8'h00)
        else $error("unmapped offset did not read zero");

    ////////////////////////////////////////////////////////////////////////
    // effective controls and link port
    chk_eq_write: assert property (
            s_write_of(`SDF_OFS_EQ) |=> s_q.tx_input_equalizer == $past(l_q.wdata))
        else $error("equalizer byte did not take the write");
    chk_emph_high: assert property (
            s_q.rx_rate_high && s_q.rx_output_preemphasis[7:4] == 4'h3
            |=> emph_db == 3'h3 && !emph_vendor)
        else $error("high rate emphasis nibble not applied");
    chk_high_vendor: assert property (
            s_q.rx_rate_high && s_q.rx_output_preemphasis[7] |=> emph_vendor && emph_db == 3'h0)
        else $error("high rate vendor code not flagged");
    chk_txoff_soft: assert property (
            s_q.soft_tx_off |=> tx_off)
        else $error("soft off did not disable the transmitter");
    chk_txoff_none: assert property (
            !s_q.soft_tx_off && !s_q.pin2[0] |=> !tx_off)
        else $error("transmitter off with no request");
    chk_rx_rate_pin: assert property (
            s_q.pin2[2] |=> rx_rate_high)
        else $error("rx rate pin did not select high rate");
    chk_tx_rate_pin: assert property (
            s_q.pin2[1] |=> tx_rate_high)
        else $error("tx rate pin did not select high rate");
    chk_done_ready: assert property (@(posedge lk_clk) disable iff (!lk_rst_b)
            lk_done |-> lk_ready)
        else $error("link not idle when access finished");
    chk_ready_drop: assert property (@(posedge lk_clk) disable iff (!lk_rst_b)
            lk_req && lk_ready |=> !lk_ready)
        else $error("link still ready after taking a request");
endmodule
`default_nettype wire

//--- test/sdf_host_model.sv
// host side model driving the link byte access port
`timescale 1ns/100ps
`default_nettype none
module sdf_host_model (
    // link clock and answer
    input  wire logic  lk_clk,
    input  wire logic  lk_ready,
    input  wire logic  lk_done,
    // request
    output logic       lk_req,
    output logic       lk_wr,
    output logic [7:0] lk_addr,
    output logic [7:0] lk_wdata
);
    initial begin
        {lk_req, lk_wr, lk_addr, lk_wdata} = 18'h00000;
    end

    // request held until a rising edge sees ready high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output bit tmo);
        int n;
        n = 0;
        @(negedge lk_clk);
        {lk_req, lk_wr, lk_addr, lk_wdata} = {1'b1, wr, a, d};
        while (lk_ready !== 1'b1 && n < 20) begin
            @(negedge lk_clk);
            n++;
        end
        @(negedge lk_clk);
        lk_req = 1'b0;
        // released address and data lines never keep the last value
        lk_addr = ~a;
        lk_wdata = ~d;
        while (lk_done !== 1'b1 && n < 40) begin
            @(negedge lk_clk);
            n++;
        end
        tmo = (n >= 40);
    endtask
endmodule
`default_nettype wire

//--- test/sfp_diag_soft_control_flags_tb_top.sv
// self-checking bench of the soft flag bank
`timescale 1ns/100ps
`default_nettype none
module sfp_diag_soft_control_flags_tb_top;
    logic             clk, rst_b, lk_clk, lk_rst_b, lk_req, lk_wr, lk_ready, lk_done;
    logic [7:0]       lk_addr, lk_wdata, lk_rdata;
    logic [4:0]       pins;
    logic             sense_valid, mon_update, tx_off, tx_rate_high, rx_rate_high, emph_vendor;
    logic [2:0]       emph_db;
    logic [6:0]       outs;
    logic [4:0][15:0] mon_value, a_hi, a_lo, w_hi, w_lo;
    logic [8:0]       exp_q[$];
    logic [8:0]       note;
    logic [31:0]      rng;
    logic [7:0]       acc[4];
    logic [1:0]       f, g;
    logic [15:0]      vals[8] = '{16'h0100, 16'h00ff, 16'h1000, 16'h1001,
                                  16'hff00, 16'h0500, 16'h0801, 16'h01ff};
    int               err_total, checked;

    assign outs = {tx_off, tx_rate_high, rx_rate_high, emph_vendor, emph_db};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        lk_clk = 1'b0;
        #7;
        forever #24 lk_clk = ~lk_clk;
    end

    sdf_flags #(.RESP_CYCLES(1000)) u_sdf_flags (
        .clk(clk), .rst_b(rst_b), .lk_clk(lk_clk), .lk_rst_b(lk_rst_b), .lk_req(lk_req),
        .lk_wr(lk_wr), .lk_addr(lk_addr), .lk_wdata(lk_wdata), .lk_ready(lk_ready),
        .lk_done(lk_done), .lk_rdata(lk_rdata), .tx_disable_pin(pins[4]),
        .tx_rate_pin_level(pins[3]), .rx_rate_pin_level(pins[2]), .tx_fault_pin(pins[1]),
        .signal_loss_pin_level(pins[0]), .sense_valid(sense_valid), .mon_update(mon_update),
        .mon_value(mon_value), .alarm_hi_lim(a_hi), .alarm_lo_lim(a_lo), .warn_hi_lim(w_hi),
        .warn_lo_lim(w_lo), .tx_off(tx_off), .tx_rate_high(tx_rate_high),
        .rx_rate_high(rx_rate_high), .emph_db(emph_db), .emph_vendor(emph_vendor));

    sdf_host_model u_sdf_host_model (.lk_clk(lk_clk), .lk_ready(lk_ready), .lk_done(lk_done),
        .lk_req(lk_req), .lk_wr(lk_wr), .lk_addr(lk_addr), .lk_wdata(lk_wdata));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [1:0] fl(input int c, input logic [15:0] v, hi, lo);
        if (c == 0)
            return {$signed(v) > $signed(hi), $signed(v) < $signed(lo)};
        return {v > hi, v < lo};
    endfunction
    task automatic print_verdict();
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] e);
        checked++;
        if (got !== e) begin
            err_total++;
            $display("[ERR] %0t read %h exp %h", $time, got, e);
        end
    endtask
    task automatic cmp_out(input logic [6:0] e);
        checked++;
        if (outs !== e) begin
            err_total++;
            $display("[ERR] %0t outs %h exp %h", $time, outs, e);
        end
    endtask
    task automatic acc_x(input logic wr, input logic [7:0] a, d, input logic [8:0] nt);
        bit tmo;
        exp_q.push_back(nt);
        u_sdf_host_model.xfer(wr, a, d, tmo);
        if (tmo) begin
            err_total++;
            print_verdict();
        end
    endtask
    task automatic wr_b(input logic [7:0] a, d);
        acc_x(1'b1, a, d, 9'h000);
    endtask
    task automatic rd_b(input logic [7:0] a, e);
        acc_x(1'b0, a, 8'h00, {1'b1, e});
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask

    // answers are matched to the oldest note
    always @(negedge lk_clk) begin
        if (lk_done === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            if (note[8])
                cmp_rd(lk_rdata, note[7:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b, lk_rst_b, pins, sense_valid, mon_update} = 9'h000;
        mon_value = '0;
        {err_total, checked} = 64'h0;
        rng = 32'd56881;
        for (int c = 0; c < 5; c++) begin
            {a_hi[c], a_lo[c], w_hi[c], w_lo[c]} = 64'h1000_0100_0800_0200;
        end
        acc = '{default: 8'h00};
        clks(12);
        rst_b = 1'b1;
        repeat (3) @(negedge lk_clk);
        lk_rst_b = 1'b1;
        repeat (2) @(negedge lk_clk);
        cmp_out(7'h00);
        rd_b(8'h6e, 8'h01);
        @(negedge clk);
        sense_valid = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            @(negedge clk);
            pins = rng[4:0];
            clks(6);
            rd_b(8'h6e, {pins[4], 1'b0, pins[3:2], 1'b0, pins[1:0], 1'b0});
            cmp_out({pins[4:2], 4'h0});
        end
        @(negedge clk);
        pins = 5'h00;
        wr_b(8'h6e, 8'hff);
        wr_b(8'h76, 8'hff);
        clks(4);
        cmp_out(7'h70);
        rd_b(8'h6e, 8'h48);
        rd_b(8'h76, 8'h08);
        for (int i = 0; i < 16; i++) begin
            wr_b(8'h73, {i[3:0], ~i[3:0]});
            clks(4);
            cmp_out({3'b111, i[3], i[3] ? 3'h0 : i[2:0]});
        end
        wr_b(8'h73, 8'h3b);
        wr_b(8'h6e, 8'h00);
        clks(4);
        cmp_out(7'h28);
        @(negedge clk);
        pins = 5'h04;
        clks(6);
        cmp_out(7'h33);
        rd_b(8'h73, 8'h3b);
        rng = xs(rng);
        wr_b(8'h72, rng[7:0]);
        clks(4);
        cmp_out(7'h33);
        rd_b(8'h72, rng[7:0]);
        wr_b(8'h70, 8'hff);
        rd_b(8'h70, 8'h00);
        rd_b(8'h80, 8'h00);
        for (int r = 0; r < 6; r++) begin
            repeat (2) begin
                @(negedge clk);
                for (int c = 0; c < 5; c++) begin
                    rng = xs(rng);
                    mon_value[c] = vals[rng[2:0]];
                    f = fl(c, mon_value[c], a_hi[c], a_lo[c]);
                    g = fl(c, mon_value[c], w_hi[c], w_lo[c]);
                    acc[c / 4][7 - 2 * (c % 4) -: 2] |= f;
                    acc[2 + c / 4][7 - 2 * (c % 4) -: 2] |= g;
                end
                mon_update = 1'b1;
                @(negedge clk);
                mon_update = 1'b0;
                clks(2);
            end
            for (int b = 0; b < 4; b++)
                rd_b(8'h70 | {5'h00, b[1], 1'b0, b[0]}, acc[b]);
            for (int b = 0; b < 4; b++)
                rd_b(8'h70 | {5'h00, b[1], 1'b0, b[0]}, 8'h00);
            acc = '{default: 8'h00};
        end
        repeat (3) @(negedge lk_clk);
        print_verdict();
    end
endmodule
`default_nettype wire
